// [rtl/rtcb_pkg.sv]
// Register map, field layouts, calendar limits and state types of the bus clock.
// Assumes one core clock, an APB master with 32-bit data and an oscillator pulse input.
package rtcb_pkg;

	localparam int RTCB_AW = 8;
	localparam int RTCB_DW = 32;
	localparam int RTCB_IW = 5;
	localparam int RTCB_BW = 8;
	localparam int RTCB_NF = 8;
	localparam int RTCB_IDX_LSB = 2;

	// Register indices; the byte address is four times the index
	localparam logic [4:0] RTCB_IDX_HUND = 5'h00;
	localparam logic [4:0] RTCB_IDX_HOUR = 5'h01;
	localparam logic [4:0] RTCB_IDX_DOW = 5'h07;
	localparam logic [4:0] RTCB_IDX_ALM = 5'h08;
	localparam logic [4:0] RTCB_IDX_ALM_END = 5'h0f;
	localparam logic [4:0] RTCB_IDX_INT = 5'h10;
	localparam logic [4:0] RTCB_IDX_CMD = 5'h11;
	localparam logic [4:0] RTCB_IDX_CFG = 5'h12;
	localparam logic [4:0] RTCB_IDX_ALAT = 5'h13;
	localparam logic [4:0] RTCB_IDX_WIN = 5'h14;
	localparam logic [4:0] RTCB_IDX_ICLR = 5'h15;

	localparam int RTCB_ST_PEND = 7;
	localparam int RTCB_ALM_MASK = 7;
	localparam int RTCB_ALM_HMASK = 6;
	localparam int RTCB_PM_BIT = 7;
	localparam logic [7:0] RTCB_CMP_FIELD = 8'h7f;
	localparam logic [7:0] RTCB_CMP_HOUR = 8'hbf;
	localparam logic [7:0] RTCB_HOUR_SEL = 8'h1f;

	localparam logic [7:0] RTCB_ONE = 8'h01;
	localparam logic [7:0] RTCB_HUND_LAST = 8'h63;
	localparam logic [7:0] RTCB_TENTH = 8'h0a;
	localparam logic [7:0] RTCB_SEC_LAST = 8'h3b;
	localparam logic [7:0] RTCB_H24_LAST = 8'h17;
	localparam logic [7:0] RTCB_H12_TOP = 8'h0c;
	localparam logic [7:0] RTCB_H12_TURN = 8'h0b;
	localparam logic [7:0] RTCB_MONTH_LAST = 8'h0c;
	localparam logic [7:0] RTCB_YEAR_LAST = 8'h63;
	localparam logic [7:0] RTCB_DOW_LAST = 8'h06;

	localparam logic [22:0] RTCB_TICK_HZ = 23'h000064;

	typedef struct packed {
		logic [7:0] dow;
		logic [7:0] year;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] hund;
	} rtcb_time_t;

	typedef struct packed {
		logic test;
		logic int_en;
		logic run;
		logic h24;
		logic [1:0] xtal;
	} rtcb_cmd_t;

	typedef struct packed {
		logic day;
		logic hour;
		logic min;
		logic sec;
		logic tenth;
		logic hund;
	} rtcb_evt_t;

	typedef struct packed {
		rtcb_time_t tm;
		rtcb_time_t hold;
		rtcb_cmd_t cmd;
		logic mux_mode;
		logic [4:0] alat;
		logic [6:0] status;
		logic [6:0] enable;
		logic [22:0] acc;
		logic [7:0] prdata;
		logic rdy;
		logic slverr;
		logic cmp;
	} rtcb_state_t;

	localparam rtcb_time_t RTCB_TIME_RST = '{dow: 8'h00, year: 8'h00, date: 8'h01,
		month: 8'h01, sec: 8'h00, min: 8'h00, hour: 8'h0c, hund: 8'h00};

	function automatic logic [22:0] rtcb_xtal_hz(input logic [1:0] code);
		unique case (code)
			2'b00: return 23'h008000;
			2'b01: return 23'h100000;
			2'b10: return 23'h200000;
			2'b11: return 23'h400000;
		endcase
	endfunction : rtcb_xtal_hz

	function automatic logic [7:0] rtcb_month_days(input logic [7:0] month, input logic [7:0] year);
		unique case (month)
			8'h02: return (year[1:0] == 2'b00) ? 8'h1d : 8'h1c;
			8'h04, 8'h06, 8'h09, 8'h0b: return 8'h1e;
			default: return 8'h1f;
		endcase
	endfunction : rtcb_month_days

endpackage : rtcb_pkg

// [rtl/rtcb_alarm_ram.sv]
// Small register-file memory for the alarm time, with a registered read port.
// Assumes one write per cycle; the full contents are also offered for comparison.
module rtcb_alarm_ram #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 8,
	parameter int AW = 3
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic we, // Write strobe
	input wire logic [AW-1:0] waddr, // Write word
	input wire logic [WIDTH-1:0] wdata, // Write data
	input wire logic [AW-1:0] raddr, // Read word
	output logic [WIDTH-1:0] rdata, // Registered read data
	output logic [DEPTH*WIDTH-1:0] contents // All words, word 0 lowest
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rdata;
	} rtcb_ram_t;

	rtcb_ram_t st_q;
	rtcb_ram_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.rdata = st_q.mem[raddr];
		if (we)
		begin
			st_d.mem[waddr] = wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign rdata = st_q.rdata;
	assign contents = st_q.mem;

endmodule : rtcb_alarm_ram

// [rtl/rtcb_cal_step.sv]
// Next calendar value after one hundredth-second, and which units advanced.
// Assumes stored values are plain binary; 12-hour hours keep the PM flag in bit 7.
module rtcb_cal_step (
	input rtcb_pkg::rtcb_time_t cur, // Present time
	input wire logic h24, // 24-hour format
	output rtcb_pkg::rtcb_time_t nxt, // Time one hundredth later
	output rtcb_pkg::rtcb_evt_t evt // Units that advanced
);
	import rtcb_pkg::*;

	logic [7:0] hund_n;
	logic [7:0] hr;

	always_comb
	begin
		nxt = cur;
		evt = '0;
		hr = cur.hour & RTCB_HOUR_SEL;
		hund_n = (cur.hund >= RTCB_HUND_LAST) ? 8'h00 : cur.hund + RTCB_ONE;
		nxt.hund = hund_n;
		evt.hund = 1'b1;
		evt.tenth = ((hund_n % RTCB_TENTH) == 8'h00);
		if (cur.hund >= RTCB_HUND_LAST)
		begin
			evt.sec = 1'b1;
			nxt.sec = (cur.sec >= RTCB_SEC_LAST) ? 8'h00 : cur.sec + RTCB_ONE;
			if (cur.sec >= RTCB_SEC_LAST)
			begin
				evt.min = 1'b1;
				nxt.min = (cur.min >= RTCB_SEC_LAST) ? 8'h00 : cur.min + RTCB_ONE;
			end
		end
		if (evt.min && cur.min >= RTCB_SEC_LAST)
		begin
			evt.hour = 1'b1;
			if (h24)
			begin
				evt.day = (cur.hour >= RTCB_H24_LAST);
				nxt.hour = evt.day ? 8'h00 : cur.hour + RTCB_ONE;
			end
			else if (hr == RTCB_H12_TURN)
			begin
				// 11 to 12 flips AM/PM; 11 PM to 12 AM is a new day
				evt.day = cur.hour[RTCB_PM_BIT];
				nxt.hour = RTCB_H12_TOP;
				nxt.hour[RTCB_PM_BIT] = ~cur.hour[RTCB_PM_BIT];
			end
			else if (hr >= RTCB_H12_TOP)
			begin
				nxt.hour = RTCB_ONE;
				nxt.hour[RTCB_PM_BIT] = cur.hour[RTCB_PM_BIT];
			end
			else
			begin
				nxt.hour = cur.hour + RTCB_ONE;
			end
		end
		if (evt.day)
		begin
			nxt.dow = (cur.dow >= RTCB_DOW_LAST) ? 8'h00 : cur.dow + RTCB_ONE;
			if (cur.date >= rtcb_month_days(cur.month, cur.year))
			begin
				nxt.date = RTCB_ONE;
				nxt.month = (cur.month >= RTCB_MONTH_LAST) ? RTCB_ONE : cur.month + RTCB_ONE;
				if (cur.month >= RTCB_MONTH_LAST)
				begin
					nxt.year = (cur.year >= RTCB_YEAR_LAST) ? 8'h00 : cur.year + RTCB_ONE;
				end
			end
			else
			begin
				nxt.date = cur.date + RTCB_ONE;
			end
		end
	end

endmodule : rtcb_cal_step

// [rtl/rtcb_top.sv]
// Real-time clock with alarm and periodic interrupts, as an APB slave.
// Assumes osc_tick pulses once per crystal period, synchronous to core_clk.
//
// What this block does
// - Register data travels as one byte
// - Eight counters, hundredths to years, read/write
// - Counters clocked from divided crystal oscillator
// - Direct or latched-address multiplexed access
// - Periodic interrupt at six selectable rates
// - Alarm RAM compared with running time
// - Status tells which source interrupted
// - Power failure switches to backup automatically
// - Backup ignores bus, keeps counting, interrupting
// - Hundredths read latches all counters
// - Hours in 12- or 24-hour format
// - Calendar with automatic leap year correction
// - Year counts to 99 then wraps
// - Write-only command register bit layout
// - Four crystal codes keep counting correct
// - Fixed map of counters, alarm, status, command
module rtcb_top (
	input wire logic core_clk, // Core clock, 40 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [rtcb_pkg::RTCB_AW-1:0] paddr, // APB byte address
	input wire logic [rtcb_pkg::RTCB_DW-1:0] pwdata, // APB write data
	output logic [rtcb_pkg::RTCB_DW-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic osc_tick, // One pulse per crystal period
	input wire logic power_fail, // Main supply lost
	output logic irq // Interrupt, active high level
);
	import rtcb_pkg::*;

	rtcb_state_t st_q;
	rtcb_state_t st_d;

	rtcb_time_t step_time;
	rtcb_evt_t step_evt;
	rtcb_time_t alarm_time;
	logic [RTCB_BW-1:0] ram_rdata;

	logic [4:0] idx;
	logic [4:0] eff;
	logic acc1;
	logic done;
	logic ok;
	logic ram_we;
	logic tick;
	logic alarm_match;
	logic pend;
	logic [22:0] sum;
	logic [22:0] xtal_hz;
	logic [6:0] set;
	logic [6:0] clr;
	logic [7:0] wdat;

	function automatic logic [4:0] rtcb_decode(input logic [RTCB_AW-1:0] a);
		return a[RTCB_IDX_LSB +: RTCB_IW];
	endfunction : rtcb_decode

	function automatic logic rtcb_valid(input logic [4:0] i, input logic mux);
		if (i > RTCB_IDX_ICLR)
		begin
			return 1'b0;
		end
		if (i == RTCB_IDX_WIN || i == RTCB_IDX_ALAT)
		begin
			return mux;
		end
		return 1'b1;
	endfunction : rtcb_valid

	function automatic logic rtcb_field_match(
		input logic [7:0] t,
		input logic [7:0] al,
		input logic ign,
		input logic [7:0] cm
	);
		return ign | ((t & cm) == (al & cm));
	endfunction : rtcb_field_match

	rtcb_cal_step u_step (
		.cur(st_q.tm),
		.h24(st_q.cmd.h24),
		.nxt(step_time),
		.evt(step_evt)
	);

	rtcb_alarm_ram #(
		.DEPTH(RTCB_NF),
		.WIDTH(RTCB_BW),
		.AW(3)
	) u_alarm (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(ram_we),
		.waddr(eff[2:0]),
		.wdata(wdat),
		.raddr(eff[2:0]),
		.rdata(ram_rdata),
		.contents(alarm_time)
	);

	// Bus phases: access cycle one loads read data, cycle two completes
	assign acc1 = psel & penable & ~st_q.rdy;
	assign done = psel & penable & st_q.rdy;
	assign idx = rtcb_decode(paddr);
	assign eff = (idx == RTCB_IDX_WIN) ? st_q.alat : idx;
	assign ok = rtcb_valid(idx, st_q.mux_mode) & ~power_fail;
	assign wdat = pwdata[RTCB_BW-1:0];
	assign ram_we = done & ok & pwrite & (eff >= RTCB_IDX_ALM) & (eff <= RTCB_IDX_ALM_END);
	assign xtal_hz = rtcb_xtal_hz(st_q.cmd.xtal);
	assign sum = st_q.acc + RTCB_TICK_HZ;
	assign pend = st_q.cmd.int_en & |(st_q.status & st_q.enable);

	// Every field must agree unless its alarm mask bit is set
	always_comb
	begin
		alarm_match = 1'b1;
		for (int i = 0; i < RTCB_NF; i++)
		begin
			if (i == int'(RTCB_IDX_HOUR))
			begin
				alarm_match &= rtcb_field_match(st_q.tm[8*i +: 8], alarm_time[8*i +: 8],
					alarm_time[8*i + RTCB_ALM_HMASK], RTCB_CMP_HOUR);
			end
			else
			begin
				alarm_match &= rtcb_field_match(st_q.tm[8*i +: 8], alarm_time[8*i +: 8],
					alarm_time[8*i + RTCB_ALM_MASK], RTCB_CMP_FIELD);
			end
		end
	end

	always_comb
	begin
		st_d = st_q;
		tick = 1'b0;
		set = '0;
		clr = '0;

		// Fractional divider: adds 100 per crystal period, so every code
		// gives exactly 100 ticks per second on average
		if (!st_q.cmd.run)
		begin
			st_d.acc = '0;
		end
		else if (osc_tick)
		begin
			if (st_q.cmd.test)
			begin
				tick = 1'b1;
			end
			else if (sum >= xtal_hz)
			begin
				tick = 1'b1;
				st_d.acc = sum - xtal_hz;
			end
			else
			begin
				st_d.acc = sum;
			end
		end

		// Counting and interrupt events go on regardless of power state
		if (tick)
		begin
			st_d.tm = step_time;
			set[6:1] = step_evt;
		end
		st_d.cmp = tick;
		if (st_q.cmp && alarm_match)
		begin
			set[0] = 1'b1;
		end

		// Read data is loaded in the first access cycle
		st_d.rdy = acc1;
		if (acc1)
		begin
			st_d.slverr = ~ok;
			st_d.prdata = '0;
			if (ok && !pwrite)
			begin
				if (eff == RTCB_IDX_HUND)
				begin
					st_d.prdata = st_q.tm.hund;
					st_d.hold = st_q.tm;
				end
				else if (eff <= RTCB_IDX_DOW)
				begin
					st_d.prdata = st_q.hold[{eff[2:0], 3'b000} +: 8];
				end
				else if (eff <= RTCB_IDX_ALM_END)
				begin
					st_d.prdata = ram_rdata;
				end
				else
				begin
					unique case (eff)
						RTCB_IDX_INT: st_d.prdata = {pend, st_q.status};
						RTCB_IDX_CFG: st_d.prdata = {7'h00, st_q.mux_mode};
						RTCB_IDX_ALAT: st_d.prdata = {3'h0, st_q.alat};
						default: st_d.prdata = '0;
					endcase
				end
			end
		end

		// Writes take effect on the completing edge, and never in backup
		if (done && ok && pwrite)
		begin
			if (eff <= RTCB_IDX_DOW)
			begin
				st_d.tm[{eff[2:0], 3'b000} +: 8] = wdat;
			end
			else
			begin
				unique case (eff)
					RTCB_IDX_INT: st_d.enable = wdat[6:0];
					RTCB_IDX_CMD: st_d.cmd = wdat[5:0];
					RTCB_IDX_CFG: st_d.mux_mode = wdat[0];
					RTCB_IDX_ALAT: st_d.alat = wdat[4:0];
					RTCB_IDX_ICLR: clr = wdat[6:0];
					default: ;
				endcase
			end
		end

		// A new event beats a clear in the same cycle
		st_d.status = (st_q.status & ~clr) | set;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
			st_q.tm <= RTCB_TIME_RST;
			st_q.hold <= RTCB_TIME_RST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign pready = done;
	assign pslverr = done & st_q.slverr;
	assign prdata = {{(RTCB_DW-RTCB_BW){1'b0}}, st_q.prdata};
	assign irq = pend;

endmodule : rtcb_top

// [dv/rtcb_osc_model.sv]
// Crystal stand-in: one osc_tick pulse every DIV core clocks.
// Assumes osc_tick is sampled on core_clk by the clock block.
module rtcb_osc_model #(
	parameter int DIV = 4
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Reset, active low
	output logic osc_tick // Crystal period pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt_q;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 0;
		else
			cnt_q <= (cnt_q == DIV - 1) ? 0 : cnt_q + 1;
	end
	assign osc_tick = (cnt_q == DIV - 1);
endmodule : rtcb_osc_model

// [dv/rtcb_asserts.sv]
// Bus and interrupt relations checked at the ports of the clock block.
// Assumes it is bound to rtcb_top.
module rtcb_asserts (
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Write
	input wire logic [rtcb_pkg::RTCB_AW-1:0] paddr, // Address
	input wire logic [rtcb_pkg::RTCB_DW-1:0] pwdata, // Write data
	input wire logic [rtcb_pkg::RTCB_DW-1:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic osc_tick, // Crystal pulse
	input wire logic power_fail, // Backup
	input wire logic irq // Interrupt
);
	import rtcb_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wait_state_a: assert property (psel && $rose(penable) |=> pready)
		else $error("no ready in second access cycle");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	ready_req_a: assert property (pready |-> psel && penable && $past(penable))
		else $error("ready without request");
	backup_err_a: assert property (pready && power_fail |-> pslverr)
		else $error("bus taken in backup");
	err_zero_a: assert property (pslverr |-> pready && prdata == '0)
		else $error("error without ready or with data");
	byte_only_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("data beyond one byte");
	cmd_wonly_a: assert property (pready && !pwrite && paddr[6:2] == RTCB_IDX_CMD |->
		prdata == '0)
		else $error("command register readable");
	irq_off_a: assert property (pready && pwrite && !pslverr && paddr[6:2] == RTCB_IDX_CMD
		&& !pwdata[4] |=> !irq)
		else $error("interrupt with interrupts disabled");
endmodule : rtcb_asserts
bind rtcb_top rtcb_asserts u_rtcb_asserts (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_tick(osc_tick), .power_fail(power_fail),
	.irq(irq));

// [dv/rtcb_top_tb.sv]
// Self-checking bench for the bus clock: register table, interrupts, backup.
// Assumes rtcb_top, rtcb_osc_model and the bound checker.
module rtcb_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rtcb_pkg::*;
	typedef struct packed {
		logic w;
		logic [4:0] i;
		logic [7:0] d;
		logic [7:0] x;
		logic e;
	} rtcb_row_t;
	localparam rtcb_row_t ROWS [12] = '{
		'{1'b0, 5'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 5'h01, 8'h00, 8'h0c, 1'b0},
		'{1'b0, 5'h04, 8'h00, 8'h01, 1'b0}, '{1'b0, 5'h05, 8'h00, 8'h01, 1'b0},
		'{1'b1, 5'h01, 8'h05, 8'h00, 1'b0}, '{1'b0, 5'h01, 8'h00, 8'h0c, 1'b0},
		'{1'b0, 5'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 5'h01, 8'h00, 8'h05, 1'b0},
		'{1'b0, 5'h11, 8'h00, 8'h00, 1'b0}, '{1'b0, 5'h16, 8'h00, 8'h00, 1'b1},
		'{1'b1, 5'h06, 8'h63, 8'h00, 1'b0}, '{1'b0, 5'h06, 8'h00, 8'h00, 1'b0}};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [RTCB_AW-1:0] paddr = '0;
	logic [RTCB_DW-1:0] pwdata = '0;
	logic [RTCB_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic osc_tick;
	logic power_fail = 1'b0;
	logic irq;
	int error_cnt = 0;
	int check_count = 0;
	logic [7:0] rd;
	logic er;
	int n;
	always #12.5 core_clk = ~core_clk;
	rtcb_osc_model #(.DIV(4)) u_rtcb_osc_model (.core_clk(core_clk), .rst_n(rst_n),
		.osc_tick(osc_tick));
	rtcb_top u_rtcb_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_tick(osc_tick), .power_fail(power_fail), .irq(irq));
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; ready, data and error are taken at the rising edge that completes it
	task automatic bus(input logic w, input logic [4:0] i, input logic [7:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {1'b0, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			chk(9'h1ff, 9'h000);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	// Load the last hundredth before a rollover, let exactly one tick through, latch
	task automatic roll(input logic [7:0] mode, input logic [7:0] hr, input logic [7:0] dt,
		input logic [7:0] mo, input logic [7:0] yr);
		bus(1'b1, RTCB_IDX_CMD, mode);
		bus(1'b1, RTCB_IDX_HUND, RTCB_HUND_LAST);
		bus(1'b1, 5'h03, RTCB_SEC_LAST);
		bus(1'b1, 5'h02, RTCB_SEC_LAST);
		bus(1'b1, RTCB_IDX_HOUR, hr);
		bus(1'b1, 5'h05, dt);
		bus(1'b1, 5'h04, mo);
		bus(1'b1, 5'h06, yr);
		// Test mode with run: the next write stops it after four core clocks, one crystal pulse
		bus(1'b1, RTCB_IDX_CMD, mode | 8'h28);
		bus(1'b1, RTCB_IDX_CMD, mode);
		bus(1'b0, RTCB_IDX_HUND, 8'h00);
	endtask : roll
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq !== 1'b1 && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask : wait_irq
	task automatic irq_is(input logic v);
		@(negedge core_clk);
		chk({8'h00, irq}, {8'h00, v});
	endtask : irq_is
	initial
	begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		end_sim();
	end
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (ROWS[r])
		begin
			bus(ROWS[r].w, ROWS[r].i, ROWS[r].d);
			chk({er, ROWS[r].w ? 8'h00 : rd}, {ROWS[r].e, ROWS[r].x});
		end
		bus(1'b0, RTCB_IDX_HUND, 8'h00);
		bus(1'b0, 5'h06, 8'h00);
		chk({er, rd}, 9'h063);
		power_fail <= 1'b1;
		bus(1'b1, RTCB_IDX_HOUR, 8'h07);
		chk({er, rd}, 9'h100);
		power_fail <= 1'b0;
		bus(1'b0, RTCB_IDX_HUND, 8'h00);
		bus(1'b0, RTCB_IDX_HOUR, 8'h00);
		chk({er, rd}, 9'h005);
		bus(1'b1, RTCB_IDX_INT, 8'h02);
		bus(1'b1, RTCB_IDX_CMD, 8'h38);
		wait_irq(500);
		chk({8'h00, irq}, 9'h001);
		bus(1'b1, RTCB_IDX_CMD, 8'h10);
		bus(1'b0, RTCB_IDX_INT, 8'h00);
		chk({er, rd & 8'h82}, 9'h082);
		bus(1'b1, RTCB_IDX_INT, 8'h00);
		irq_is(1'b0);
		bus(1'b1, RTCB_IDX_INT, 8'h02);
		irq_is(1'b1);
		bus(1'b1, RTCB_IDX_CMD, 8'h00);
		irq_is(1'b0);
		bus(1'b1, RTCB_IDX_CMD, 8'h10);
		irq_is(1'b1);
		bus(1'b1, RTCB_IDX_ICLR, 8'h7f);
		irq_is(1'b0);
		// 24-hour: the last hundredth of a year carries through every counter
		roll(8'h04, RTCB_H24_LAST, 8'h1f, RTCB_MONTH_LAST, RTCB_YEAR_LAST);
		chk({er, rd}, 9'h000);
		bus(1'b0, RTCB_IDX_HOUR, 8'h00);
		chk({er, rd}, 9'h000);
		bus(1'b0, 5'h05, 8'h00);
		chk({er, rd}, 9'h001);
		bus(1'b0, 5'h04, 8'h00);
		chk({er, rd}, 9'h001);
		bus(1'b0, 5'h06, 8'h00);
		chk({er, rd}, 9'h000);
		// 12-hour: 11 PM on 28 February of a leap year
		roll(8'h00, 8'h8b, 8'h1c, 8'h02, 8'h04);
		bus(1'b0, RTCB_IDX_HOUR, 8'h00);
		chk({er, rd}, 9'h00c);
		bus(1'b0, 5'h05, 8'h00);
		chk({er, rd}, 9'h01d);
		// Multiplexed access: latch the index, then write through the window
		bus(1'b1, RTCB_IDX_CFG, 8'h01);
		bus(1'b1, RTCB_IDX_ALAT, {3'h0, RTCB_IDX_ALM});
		bus(1'b1, RTCB_IDX_WIN, 8'h05);
		bus(1'b0, RTCB_IDX_ALM, 8'h00);
		chk({er, rd}, 9'h005);
		// Alarm on hundredths 5 only; every other field masked
		for (int a = 9; a < 16; a++)
			bus(1'b1, 5'(a), (a == 9) ? 8'h40 : 8'h80);
		bus(1'b1, RTCB_IDX_INT, 8'h01);
		bus(1'b1, RTCB_IDX_CMD, 8'h38);
		wait_irq(1000);
		chk({8'h00, irq}, 9'h001);
		bus(1'b0, RTCB_IDX_INT, 8'h00);
		chk({er, rd & 8'h81}, 9'h081);
		// Reset in mid-run drops the interrupt and restores the time
		rst_n <= 1'b0;
		irq_is(1'b0);
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(1'b0, RTCB_IDX_HUND, 8'h00);
		bus(1'b0, RTCB_IDX_HOUR, 8'h00);
		chk({er, rd}, 9'h00c);
		// Code 0 at run: 328 crystal periods of 4 clocks to the first hundredth
		bus(1'b1, RTCB_IDX_INT, 8'h02);
		bus(1'b1, RTCB_IDX_CMD, 8'h18);
		wait_irq(2000);
		chk({8'h00, n >= 1308 && n <= 1316}, 9'h001);
		end_sim();
	end
endmodule : rtcb_top_tb
